// ---- ltc_pkg.sv ----
// constants for the four-channel transmit control block
package ltc_pkg;
    localparam int          NUM_CH         = 4;
    localparam int          WORD_W         = 2;
    localparam int          BUF_DEPTH      = 2;
    localparam logic [7:0]  CHAN_CTRL_OFS  = 8'h10;
    localparam logic [7:0]  GLOBAL_OFS     = 8'h42;
    localparam logic [7:0]  STATUS_OFS     = 8'h43;
    localparam int          PIN_SEL_BIT    = 6;
    localparam int          TXON_BIT       = 0;
    localparam int          RXPWR_BIT      = 1;
    localparam logic [7:0]  CHAN_CTRL_RST  = 8'h02;
    localparam logic [7:0]  GLOBAL_RST     = 8'h00;
    localparam int          PIN_WR         = 0;
    localparam int          PIN_RD         = 1;
    localparam int          PIN_ALE        = 2;
    localparam int          PIN_CS         = 3;
endpackage : ltc_pkg

// ---- ltc_buf_if.sv ----
// handshake bundle around one channel's two-entry buffer
`timescale 1ns/1ns
interface ltc_buf_if #(parameter int WIDTH = 2);
    logic             in_valid;
    logic             in_ready;
    logic [WIDTH-1:0] in_data;
    logic             out_valid;
    logic             out_ready;
    logic [WIDTH-1:0] out_data;
    modport buf_side  (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user_side (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : ltc_buf_if

// ---- ltc_pair_buffer.sv ----
// two-entry fifo holding sampled line symbols
`timescale 1ns/1ns
module ltc_pair_buffer
    import ltc_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = BUF_DEPTH
) (
    input  wire logic  core_clk,
    input  wire logic  sys_rst,
    ltc_buf_if.buf_side bus
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [PW:0]      next_count;
    logic             push;
    logic             pop;

    assign bus.in_ready  = (count != DEPTH[PW:0]);
    assign bus.out_valid = (count != '0);
    assign bus.out_data  = mem[rd_ptr];
    assign push          = bus.in_valid & bus.in_ready;
    assign pop           = bus.out_valid & bus.out_ready;

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
        if (push) begin
            mem[wr_ptr] <= bus.in_data;
        end
    end
endmodule : ltc_pair_buffer

// ---- ltc_transmit_control.sv ----
// four-channel transmit control with shared-pin processor bus
// Notes on behaviour
// R1: each channel samples its positive and negative data on its own line clock.
// R2: the channel's line clock paces every transmit-direction event of that channel; driver outputs here move when line_ready takes a symbol.
// R3: system side supplies 1.544MHz line clock for T1, 2.048MHz for E1.
// R4: hardware mode, all-ones command high: send unframed all-ones instead of data.
// R5: hardware mode, all-ones command low: send the applied normal traffic.
// R6: host mode turns the four command pins into write, read, latch, select.
// R7: hardware mode, transmitter-on pin high enables transmit only, never the receiver.
// R8: transmitter-on control at 0 puts both driver outputs in high impedance.
// R9: hardware mode powers all receivers on and offers no way to power them off.
// R10: host mode lets each receiver be powered on or off by register.
// R11: host mode, per-channel control register bit decides transmitter on by default.
// R12: host mode, writing 1 to bit 6 at 0x42 hands control to pins.
// R13: mode-select low selects host mode; high selects hardware mode.
`timescale 1ns/1ns
module ltc_transmit_control
    import ltc_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 config_mode_select,
    input  wire logic [ltc_pkg::NUM_CH-1:0] transmit_line_clock,
    input  wire logic [ltc_pkg::NUM_CH-1:0] transmit_positive_data,
    input  wire logic [ltc_pkg::NUM_CH-1:0] transmit_negative_data,
    input  wire logic [ltc_pkg::NUM_CH-1:0] transmit_all_ones_cmd,
    input  wire logic [ltc_pkg::NUM_CH-1:0] transmitter_on,
    input  wire logic [ltc_pkg::NUM_CH-1:0] line_ready,
    input  wire logic [7:0]           cpu_addr,
    input  wire logic [7:0]           cpu_data_in,
    output logic      [7:0]           cpu_data_out,
    output logic      [7:0]           cpu_data_oe,
    output logic      [ltc_pkg::NUM_CH-1:0] transmit_data_ready,
    output logic      [ltc_pkg::NUM_CH-1:0] line_driver_tip_out,
    output logic      [ltc_pkg::NUM_CH-1:0] line_driver_ring_out,
    output logic      [ltc_pkg::NUM_CH-1:0] line_driver_oe,
    output logic      [ltc_pkg::NUM_CH-1:0] receiver_power_on
);
    logic             host_mode;
    logic             cpu_write_strobe_n;
    logic             cpu_read_strobe_n;
    logic             cpu_address_latch;
    logic             cpu_chip_select_n;
    logic [7:0]       latched_addr;
    logic [7:0]       next_latched_addr;
    logic             prev_wr_n;
    logic             wr_commit;
    logic [7:0]       global_transmit_on_source_control;
    logic [7:0]       next_global;
    logic [7:0]       chan_ctrl [NUM_CH];
    logic [7:0]       next_chan_ctrl [NUM_CH];
    logic [7:0]       read_mux;
    logic [7:0]       next_data_out;
    logic [NUM_CH-1:0] buf_full;
    logic [NUM_CH-1:0] tx_enable;
    logic             use_pins;
    logic             global_hit;
    logic             status_hit;
    logic [NUM_CH-1:0] chan_hit;

    assign host_mode          = ~config_mode_select; // R13
    // shared pins only mean bus signals in host mode
    assign cpu_write_strobe_n = host_mode ? transmit_all_ones_cmd[PIN_WR]  : 1'b1; // R6
    assign cpu_read_strobe_n  = host_mode ? transmit_all_ones_cmd[PIN_RD]  : 1'b1; // R6
    assign cpu_address_latch  = host_mode ? transmit_all_ones_cmd[PIN_ALE] : 1'b0; // R6
    assign cpu_chip_select_n  = host_mode ? transmit_all_ones_cmd[PIN_CS]  : 1'b1; // R6
    // write commits on the rising edge of the write strobe
    assign wr_commit          = ~prev_wr_n & cpu_write_strobe_n & ~cpu_chip_select_n;
    assign cpu_data_oe        = {8{~cpu_read_strobe_n & ~cpu_chip_select_n}};
    // hardware mode ignores the select bit and always obeys the pins
    assign use_pins           = ~host_mode | global_transmit_on_source_control[PIN_SEL_BIT]; // R12

    // one address decoder feeds both the write and the read side
    assign global_hit = (latched_addr == GLOBAL_OFS);
    assign status_hit = (latched_addr == STATUS_OFS);
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            chan_hit[c] = (latched_addr == CHAN_CTRL_OFS + 8'(c));
        end
    end

    // the address stays latched after the latch pin falls
    always_comb begin
        next_latched_addr = cpu_address_latch ? cpu_addr : latched_addr;
        next_global       = global_transmit_on_source_control;
        for (int c = 0; c < NUM_CH; c++) begin
            next_chan_ctrl[c] = chan_ctrl[c];
        end
        if (wr_commit) begin
            if (global_hit) begin
                next_global = cpu_data_in; // R12
            end
            for (int c = 0; c < NUM_CH; c++) begin
                if (chan_hit[c]) begin
                    next_chan_ctrl[c] = cpu_data_in; // R10 R11
                end
            end
        end
    end

    // unmapped addresses read as zero
    always_comb begin
        read_mux = 8'h00;
        if (global_hit) begin
            read_mux = global_transmit_on_source_control;
        end else if (status_hit) begin
            read_mux = {buf_full, tx_enable};
        end
        for (int c = 0; c < NUM_CH; c++) begin
            if (chan_hit[c]) begin
                read_mux = chan_ctrl[c];
            end
        end
        next_data_out = read_mux;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            latched_addr                      <= 8'h00;
            prev_wr_n                         <= 1'b1;
            global_transmit_on_source_control <= GLOBAL_RST;
            cpu_data_out                      <= 8'h00;
            for (int c = 0; c < NUM_CH; c++) begin
                chan_ctrl[c] <= CHAN_CTRL_RST;
            end
        end else begin
            latched_addr                      <= next_latched_addr;
            prev_wr_n                         <= cpu_write_strobe_n;
            global_transmit_on_source_control <= next_global;
            cpu_data_out                      <= next_data_out;
            for (int c = 0; c < NUM_CH; c++) begin
                chan_ctrl[c] <= next_chan_ctrl[c];
            end
        end
    end

    // per-channel transmit path, sampled on that channel's line clock, drained by line_ready
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        ltc_buf_if #(.WIDTH(WORD_W)) buf_bus ();
        logic              prev_line_clk;
        logic              line_clk_rise;
        logic              all_ones;
        logic              mark_phase;
        logic              next_mark_phase;
        logic              tip;
        logic              ring;
        logic              next_tip;
        logic              next_ring;
        logic [WORD_W-1:0] symbol;
        logic              line_pop;

        // a rise is a low sample followed by a high one
        assign line_clk_rise = transmit_line_clock[ch] & ~prev_line_clk; // R2
        assign all_ones      = ~host_mode & transmit_all_ones_cmd[ch];
        always_comb begin
            if (all_ones) begin
                symbol = {mark_phase, ~mark_phase}; // R4
            end else begin
                symbol = {transmit_positive_data[ch], transmit_negative_data[ch]}; // R5
            end
        end
        // a rise while both entries are full drops that symbol
        assign buf_bus.in_valid = line_clk_rise; // R1
        assign buf_bus.in_data  = symbol; // R1
        assign buf_bus.out_ready = line_ready[ch];
        assign transmit_data_ready[ch] = buf_bus.in_ready;
        assign buf_full[ch] = ~buf_bus.in_ready;
        assign line_pop     = buf_bus.out_valid & buf_bus.out_ready;

        // marks alternate polarity so all-ones stays balanced on the line
        always_comb begin
            next_mark_phase = mark_phase;
            if (line_clk_rise && buf_bus.in_ready && all_ones) begin
                next_mark_phase = ~mark_phase; // R4
            end
        end

        // driver data only moves when the next stage takes a symbol
        always_comb begin
            next_tip  = tip;
            next_ring = ring;
            if (line_pop) begin
                next_tip  = buf_bus.out_data[1];
                next_ring = buf_bus.out_data[0];
            end
        end

        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                prev_line_clk <= 1'b0;
                mark_phase    <= 1'b1;
                tip           <= 1'b0;
                ring          <= 1'b0;
            end else begin
                prev_line_clk <= transmit_line_clock[ch];
                mark_phase    <= next_mark_phase;
                tip           <= next_tip;
                ring          <= next_ring;
            end
        end

        ltc_pair_buffer #(.WIDTH(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
            .core_clk (core_clk),
            .sys_rst  (sys_rst),
            .bus      (buf_bus)
        );

        always_comb begin
            if (use_pins) begin
                tx_enable[ch] = transmitter_on[ch]; // R7 R12
            end else begin
                tx_enable[ch] = chan_ctrl[ch][TXON_BIT]; // R11
            end
        end
        assign line_driver_tip_out[ch]  = tip;
        assign line_driver_ring_out[ch] = ring;
        assign line_driver_oe[ch]       = tx_enable[ch]; // R8
        // receiver never follows the transmitter-on pin
        assign receiver_power_on[ch] = host_mode ? chan_ctrl[ch][RXPWR_BIT] : 1'b1; // R9 R10 R7
    end
endmodule : ltc_transmit_control

// ---- ltc_transmit_control_checker.sv ----
// port-level assertions for the transmit control block
`timescale 1ns/1ns
module ltc_transmit_control_checker (
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic       config_mode_select,
    input wire logic [3:0] transmitter_on,
    input wire logic [3:0] transmit_all_ones_cmd,
    input wire logic [7:0] cpu_data_oe,
    input wire logic [3:0] line_driver_oe,
    input wire logic [3:0] line_driver_tip_out,
    input wire logic [3:0] line_driver_ring_out,
    input wire logic [3:0] transmit_data_ready,
    input wire logic [3:0] receiver_power_on
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    AST_HW_OE_PIN: assert property (config_mode_select |-> line_driver_oe == transmitter_on)
        else $error("driver enable differs from pin");
    AST_HW_OFF_HIZ: assert property (config_mode_select && !transmitter_on[0] |-> !line_driver_oe[0])
        else $error("driver not released");
    AST_HW_RX_ON: assert property (config_mode_select |-> receiver_power_on == 4'hF)
        else $error("receiver off in hardware mode");
    AST_HW_RX_STILL: assert property (config_mode_select && $past(config_mode_select) |-> $stable(receiver_power_on))
        else $error("receiver power moved");
    AST_HW_NO_BUS: assert property (config_mode_select |-> cpu_data_oe == 8'h00)
        else $error("bus driven in hardware mode");
    AST_HOST_RD_OE: assert property (!config_mode_select && !transmit_all_ones_cmd[1] && !transmit_all_ones_cmd[3]
        |-> cpu_data_oe == 8'hFF)
        else $error("read not driven");
    AST_HOST_IDLE_OE: assert property (!config_mode_select && transmit_all_ones_cmd[1] |-> cpu_data_oe == 8'h00)
        else $error("bus driven without read");
    AST_RST_IDLE: assert property ($fell(sys_rst) |-> line_driver_tip_out == 4'h0 && line_driver_ring_out == 4'h0
        && transmit_data_ready == 4'hF)
        else $error("not idle after reset");
endmodule : ltc_transmit_control_checker

// ---- ltc_line_source.sv ----
// system-side source of line clock and dual-rail data
`timescale 1ns/1ns
module ltc_line_source (
    input  wire logic       core_clk,
    output logic      [3:0] transmit_line_clock,
    output logic      [3:0] transmit_positive_data,
    output logic      [3:0] transmit_negative_data
);
    // core clock cycles per line clock period for the t1 and e1 rates
    localparam int T1_PERIOD = 162;
    localparam int E1_PERIOD = 122;
    initial begin
        transmit_line_clock = 4'h0;
        transmit_positive_data = 4'h0;
        transmit_negative_data = 4'h0;
    end
    // one symbol per line clock period at the chosen rate, clock still between symbols
    task automatic sym(input int ch, input logic p, input logic n, input logic e1);
        int half;
        half = (e1 ? E1_PERIOD : T1_PERIOD) / 2;
        @(negedge core_clk);
        transmit_positive_data[ch] = p;
        transmit_negative_data[ch] = n;
        @(negedge core_clk);
        transmit_line_clock[ch] = 1'b1;
        repeat (half) @(negedge core_clk);
        transmit_line_clock[ch] = 1'b0;
        transmit_positive_data[ch] = ~p;
        transmit_negative_data[ch] = ~n;
        repeat (half - 2) @(negedge core_clk);
    endtask : sym
endmodule : ltc_line_source

// ---- ltc_transmit_control_tb_top.sv ----
// self-checking bench for the transmit control block
`timescale 1ns/1ns
module ltc_transmit_control_tb_top;
    import ltc_pkg::*;
    logic        core_clk, sys_rst, config_mode_select;
    logic [3:0]  transmit_all_ones_cmd, transmitter_on, line_ready, transmit_line_clock;
    logic [3:0]  transmit_positive_data, transmit_negative_data, transmit_data_ready;
    logic [3:0]  line_driver_tip_out, line_driver_ring_out, line_driver_oe, receiver_power_on;
    logic [7:0]  cpu_addr, cpu_data_in, cpu_data_out, cpu_data_oe, q;
    logic [31:0] seed = 32'h0000001E;
    int          n_mismatch = 0;
    int          checks = 0;
    logic        mark_hi = 1'b1;
    logic [7:0]  ra[6] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h42, 8'h7F};
    logic [7:0]  rv[6] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h00, 8'h00};
    ltc_transmit_control ltc_transmit_control_i (.*);
    ltc_line_source ltc_line_source_i (.core_clk, .transmit_line_clock, .transmit_positive_data,
        .transmit_negative_data);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [1:0] exp_sym(logic aos, logic p, logic n, logic mark);
        if (aos) begin
            return {mark, ~mark};
        end
        return {p, n};
    endfunction : exp_sym
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic tx(input int ch, input logic aos);
        logic [31:0] r;
        logic [1:0]  e;
        r = rnd();
        e = exp_sym(aos, r[0], r[1], mark_hi);
        if (aos) begin
            mark_hi = ~mark_hi;
        end
        ltc_line_source_i.sym(ch, r[0], r[1], r[2]);
        repeat (3) @(negedge core_clk);
        chk("symbol", {6'h00, e}, {6'h00, line_driver_tip_out[ch], line_driver_ring_out[ch]});
    endtask : tx
    // host bus cycle on the shared pins: ale, then strobe under select
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        cpu_addr = a;
        transmit_all_ones_cmd = 4'b1111;
        @(negedge core_clk);
        transmit_all_ones_cmd = 4'b1011;
        cpu_data_in = d;
        @(negedge core_clk);
        transmit_all_ones_cmd = wr ? 4'b0010 : 4'b0001;
        repeat (2) @(negedge core_clk);
        q = cpu_data_out;
        transmit_all_ones_cmd = 4'b0011;
        @(negedge core_clk);
        transmit_all_ones_cmd = 4'b1011;
    endtask : bus
    task automatic pop0(input logic [1:0] e);
        line_ready = 4'hF;
        @(negedge core_clk);
        line_ready = 4'hE;
        repeat (3) @(negedge core_clk);
        chk("held symbol", {6'h00, e}, {6'h00, line_driver_tip_out[0], line_driver_ring_out[0]});
    endtask : pop0
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        end_sim();
    end
    initial begin
        {sys_rst, config_mode_select, transmit_all_ones_cmd, transmitter_on} = {2'b11, 4'h8, 4'hF};
        {line_ready, cpu_addr, cpu_data_in} = {4'hF, 16'h0000};
        repeat (10) @(negedge core_clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 24; i++) begin
            transmitter_on = 4'(rnd());
            tx(i % 4, i % 4 == 3);
            chk("oe hw", {4'h0, transmitter_on}, {4'h0, line_driver_oe});
            chk("rx hw", 8'h0F, {4'h0, receiver_power_on});
        end
        line_ready = 4'hE;
        ltc_line_source_i.sym(0, 1'b1, 1'b0, 1'b0);
        ltc_line_source_i.sym(0, 1'b0, 1'b1, 1'b1);
        ltc_line_source_i.sym(0, 1'b1, 1'b1, 1'b0);
        chk("full", 8'h00, {7'h00, transmit_data_ready[0]});
        pop0(2'b10);
        pop0(2'b01);
        pop0(2'b01);
        {config_mode_select, transmit_all_ones_cmd} = {1'b0, 4'b1011};
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, ra[i], 8'h00);
            chk("reg", rv[i], q);
        end
        chk("oe host", 8'h00, {4'h0, line_driver_oe});
        bus(1'b1, 8'h10, 8'h01);
        bus(1'b1, 8'h11, 8'h00);
        bus(1'b1, 8'h7F, 8'hFF);
        transmitter_on = 4'h0;
        chk("oe reg", 8'h01, {4'h0, line_driver_oe});
        chk("rx reg", 8'h0C, {4'h0, receiver_power_on});
        bus(1'b1, GLOBAL_OFS, 8'h40);
        transmitter_on = 4'hA;
        bus(1'b0, GLOBAL_OFS, 8'h00);
        chk("sel", 8'h40, q);
        chk("oe pin", 8'h0A, {4'h0, line_driver_oe});
        bus(1'b0, STATUS_OFS, 8'h00);
        chk("status", 8'h0A, q);
        bus(1'b0, 8'h7F, 8'h00);
        chk("unmapped", 8'h00, q);
        end_sim();
    end
endmodule : ltc_transmit_control_tb_top
bind ltc_transmit_control ltc_transmit_control_checker ltc_transmit_control_checker_i (.core_clk, .sys_rst,
    .config_mode_select, .transmitter_on, .transmit_all_ones_cmd, .cpu_data_oe, .line_driver_oe,
    .line_driver_tip_out, .line_driver_ring_out, .transmit_data_ready, .receiver_power_on);
